// ===== spu_pkg.sv
package spu_pkg;

    localparam longint CORE_PERIOD_NS = 50;
    // Gear clock of the target is assumed 1 MHz; slower targets need a larger figure
    localparam longint GEAR_PERIOD_NS = 1000;
    localparam longint BAUD_RATE      = 9600;
    localparam longint UART_DIV       = 1000000000 / (CORE_PERIOD_NS * BAUD_RATE);

    localparam longint RESET_HOLD_MS  = 10;
    localparam longint START_WAIT_MS  = 20;
    localparam longint GAP_SYNC1_GEAR = 140;
    localparam longint GAP_SYNC2_GEAR = 90;
    localparam longint GAP_CMD_GEAR   = 270;
    localparam longint NEXT_CMD_GEAR  = 1100;
    localparam longint ECHO_MAX_GEAR  = 660;

    localparam logic [7:0] SYNC1_BYTE    = 8'h86;
    localparam logic [7:0] SYNC2_BYTE    = 8'h79;
    localparam logic [7:0] CMD_ERASE     = 8'hF0;
    localparam logic [7:0] CMD_WRITE     = 8'h30;
    localparam logic [7:0] CMD_READ      = 8'h40;
    localparam logic [7:0] CMD_SUM       = 8'h90;
    localparam logic [7:0] CMD_PROD_ID   = 8'hC0;
    localparam logic [7:0] CMD_STATUS    = 8'hC3;
    localparam logic [7:0] CMD_EMULATION = 8'hD0;

    // Least waits round up to whole core cycles
    function automatic logic [31:0] ns_to_cycles(input longint ns);
        return 32'((ns + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
    endfunction : ns_to_cycles

    function automatic logic [31:0] gear_to_cycles(input longint gear);
        return ns_to_cycles(gear * GEAR_PERIOD_NS);
    endfunction : gear_to_cycles

    localparam logic [31:0] RESET_HOLD_CYC = ns_to_cycles(RESET_HOLD_MS * 1000000);
    localparam logic [31:0] START_WAIT_CYC = ns_to_cycles(START_WAIT_MS * 1000000);
    localparam logic [31:0] GAP_SYNC1_CYC  = gear_to_cycles(GAP_SYNC1_GEAR);
    localparam logic [31:0] GAP_SYNC2_CYC  = gear_to_cycles(GAP_SYNC2_GEAR);
    localparam logic [31:0] GAP_CMD_CYC    = gear_to_cycles(GAP_CMD_GEAR);
    localparam logic [31:0] NEXT_CMD_CYC   = gear_to_cycles(NEXT_CMD_GEAR);
    // Four times the echo time plus four character times of margin
    localparam logic [31:0] ECHO_TMO_CYC   = gear_to_cycles(ECHO_MAX_GEAR * 4) +
                                             32'(UART_DIV * 40);

    function automatic logic cmd_known(input logic [7:0] code);
        return code inside {CMD_ERASE, CMD_WRITE, CMD_READ, CMD_SUM,
                            CMD_PROD_ID, CMD_STATUS, CMD_EMULATION};
    endfunction : cmd_known

    typedef enum {
        SPU_IDLE, SPU_HOLD, SPU_START, SPU_SEND, SPU_ECHO,
        SPU_GAP, SPU_READY, SPU_DATA, SPU_NEXT, SPU_ERR
    } spu_state_t;

    typedef enum {SPU_PH_SYNC1, SPU_PH_SYNC2, SPU_PH_CMD} spu_phase_t;

endpackage : spu_pkg

// ===== spu_uart_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spu_uart_if;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       tx_ready;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_err;

    modport ctl (output tx_valid, output tx_data, input tx_ready,
                 input rx_valid, input rx_data, input rx_err);
    modport phy (input tx_valid, input tx_data, output tx_ready,
                 output rx_valid, output rx_data, output rx_err);
endinterface : spu_uart_if
`default_nettype wire

// ===== spu_uart.sv
`timescale 1ns/100ps
`default_nettype none
module spu_uart
    import spu_pkg::*;
#(
    parameter int DIV = int'(UART_DIV)
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Byte channel
    spu_uart_if.phy   link,
    // Pins
    input  wire logic rxd,
    output var  logic txd
);
    logic [15:0] tx_div, next_tx_div;
    logic [3:0]  tx_bits, next_tx_bits;
    logic [9:0]  tx_shift, next_tx_shift;
    logic        tx_idle, next_tx_idle;
    logic        next_txd;

    logic        rx_meta, rx_sync;
    logic [15:0] rx_div, next_rx_div;
    logic [3:0]  rx_bits, next_rx_bits;
    logic [7:0]  rx_shift, next_rx_shift;
    logic        rx_busy, next_rx_busy;
    logic        next_rx_valid, next_rx_err;
    logic [7:0]  next_rx_data;

    // Transmit: start bit, eight data bits low first, stop bit
    always_comb begin
        next_tx_div   = tx_div;
        next_tx_bits  = tx_bits;
        next_tx_shift = tx_shift;
        next_tx_idle  = tx_idle;
        next_txd      = txd;
        if (tx_idle) begin
            if (link.tx_valid) begin
                next_tx_shift = {1'b1, link.tx_data, 1'b0};
                next_tx_bits  = 4'hA;
                next_tx_div   = 16'h0000;
                next_tx_idle  = 1'b0;
            end
        end else if (tx_div == 16'(DIV - 1)) begin
            next_tx_div = 16'h0000;
            if (tx_bits == 4'h0) begin
                next_tx_idle = 1'b1;
            end
        end else begin
            next_tx_div = tx_div + 16'h0001;
        end
        if (!tx_idle && tx_div == 16'h0000 && tx_bits != 4'h0) begin
            next_txd      = tx_shift[0];
            next_tx_shift = {1'b1, tx_shift[9:1]};
            next_tx_bits  = tx_bits - 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_div   <= 16'h0000;
            tx_bits  <= 4'h0;
            tx_shift <= 10'h3FF;
            tx_idle  <= 1'b1;
            txd      <= 1'b1;
        end else begin
            tx_div   <= next_tx_div;
            tx_bits  <= next_tx_bits;
            tx_shift <= next_tx_shift;
            tx_idle  <= next_tx_idle;
            txd      <= next_txd;
        end
    end

    assign link.tx_ready = tx_idle;

    // Receive: sample mid-bit, stop bit low counts as framing error
    always_comb begin
        next_rx_div   = rx_div;
        next_rx_bits  = rx_bits;
        next_rx_shift = rx_shift;
        next_rx_busy  = rx_busy;
        next_rx_valid = 1'b0;
        next_rx_err   = 1'b0;
        next_rx_data  = link.rx_data;
        if (!rx_busy) begin
            if (!rx_sync) begin
                next_rx_busy = 1'b1;
                next_rx_bits = 4'h0;
                next_rx_div  = 16'(DIV / 2);
            end
        end else if (rx_div == 16'(DIV - 1)) begin
            next_rx_div  = 16'h0000;
            next_rx_bits = rx_bits + 4'h1;
            if (rx_bits == 4'h0 && rx_sync) begin
                next_rx_busy = 1'b0;
            end else if (rx_bits == 4'h9) begin
                next_rx_busy  = 1'b0;
                next_rx_valid = rx_sync;
                next_rx_err   = !rx_sync;
                next_rx_data  = rx_shift;
            end else if (rx_bits != 4'h0) begin
                next_rx_shift = {rx_sync, rx_shift[7:1]};
            end
        end else begin
            next_rx_div = rx_div + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_meta       <= 1'b1;
            rx_sync       <= 1'b1;
            rx_div        <= 16'h0000;
            rx_bits       <= 4'h0;
            rx_shift      <= 8'h00;
            rx_busy       <= 1'b0;
            link.rx_valid <= 1'b0;
            link.rx_err   <= 1'b0;
            link.rx_data  <= 8'h00;
        end else begin
            rx_meta       <= rxd;
            rx_sync       <= rx_meta;
            rx_div        <= next_rx_div;
            rx_bits       <= next_rx_bits;
            rx_shift      <= next_rx_shift;
            rx_busy       <= next_rx_busy;
            link.rx_valid <= next_rx_valid;
            link.rx_err   <= next_rx_err;
            link.rx_data  <= next_rx_data;
        end
    end
endmodule : spu_uart
`default_nettype wire

// ===== spu_host.sv
`timescale 1ns/100ps
`default_nettype none
module spu_host
    import spu_pkg::*;
#(
    parameter logic [31:0] RESET_HOLD = RESET_HOLD_CYC,
    parameter logic [31:0] START_WAIT = START_WAIT_CYC,
    parameter logic [31:0] NEXT_WAIT  = NEXT_CMD_CYC,
    parameter logic [31:0] ECHO_TMO   = ECHO_TMO_CYC,
    parameter int          BAUD_DIV   = int'(UART_DIV)
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Session and command requests
    input  wire logic       session_start,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic       cmd_done,
    // Data bytes toward the device
    input  wire logic       data_valid,
    input  wire logic [7:0] data_byte,
    output var  logic       data_ready,
    // Bytes from the device
    output var  logic       resp_valid,
    output var  logic [7:0] resp_byte,
    // Status
    output var  logic       cmd_ready,
    output var  logic       cmd_reject,
    output var  logic       link_error,
    // Device pins
    output var  logic       dev_mode,
    output var  logic       dev_reset_n,
    output var  logic       dev_rxd,
    input  wire logic       dev_txd
);
    spu_uart_if link ();

    spu_uart #(
        .DIV (BAUD_DIV)
    ) u_uart (
        .core_clk (core_clk),
        .srst     (srst),
        .link     (link.phy),
        .rxd      (dev_txd),
        .txd      (dev_rxd)
    );

    spu_state_t  state, next_state;
    spu_phase_t  phase, next_phase;
    logic [31:0] cnt, next_cnt;
    logic [7:0]  sent, next_sent;
    logic        tx_valid, next_tx_valid;
    logic        next_data_ready, next_resp_valid, next_cmd_ready;
    logic        next_cmd_reject, next_link_error, next_mode, next_reset_n;
    logic [7:0]  next_resp_byte;

    assign link.tx_valid = tx_valid;
    assign link.tx_data  = sent;

    always_comb begin
        next_state      = state;
        next_phase      = phase;
        next_cnt        = (cnt != 32'h0000_0000) ? cnt - 32'h0000_0001 : cnt;
        next_sent       = sent;
        next_tx_valid   = tx_valid;
        next_data_ready = data_ready;
        next_resp_valid = 1'b0;
        next_resp_byte  = resp_byte;
        next_cmd_ready  = 1'b0;
        next_cmd_reject = 1'b0;
        next_link_error = link_error;
        next_mode       = dev_mode;
        next_reset_n    = dev_reset_n;
        if (tx_valid && link.tx_ready) begin
            next_tx_valid = 1'b0;
        end
        case (state)
            SPU_IDLE: begin
            end
            SPU_HOLD: begin
                if (cnt == 32'h0000_0000) begin
                    next_mode    = 1'b1;
                    next_reset_n = 1'b1;
                    next_cnt     = START_WAIT;
                    next_state   = SPU_START;
                end
            end
            SPU_START: begin
                if (cnt == 32'h0000_0000) begin
                    next_sent     = SYNC1_BYTE;
                    next_phase    = SPU_PH_SYNC1;
                    next_tx_valid = 1'b1;
                    next_state    = SPU_SEND;
                end
            end
            SPU_SEND: begin
                if (tx_valid && link.tx_ready) begin
                    next_cnt   = ECHO_TMO;
                    next_state = SPU_ECHO;
                end
            end
            SPU_ECHO: begin
                // Every setup and command byte must come back unchanged
                if (link.rx_valid) begin
                    if (link.rx_data != sent) begin
                        next_link_error = 1'b1;
                        next_state      = SPU_ERR;
                    end else begin
                        next_state = SPU_GAP;
                        case (phase)
                            SPU_PH_SYNC1: next_cnt = GAP_SYNC1_CYC;
                            SPU_PH_SYNC2: next_cnt = GAP_SYNC2_CYC;
                            SPU_PH_CMD:   next_cnt = GAP_CMD_CYC;
                            default:      next_cnt = GAP_CMD_CYC;
                        endcase
                    end
                end else if (link.rx_err || cnt == 32'h0000_0000) begin
                    next_link_error = 1'b1;
                    next_state      = SPU_ERR;
                end
            end
            SPU_GAP: begin
                if (cnt == 32'h0000_0000) begin
                    case (phase)
                        SPU_PH_SYNC1: begin
                            next_sent     = SYNC2_BYTE;
                            next_phase    = SPU_PH_SYNC2;
                            next_tx_valid = 1'b1;
                            next_state    = SPU_SEND;
                        end
                        SPU_PH_SYNC2: begin
                            next_cmd_ready = 1'b1;
                            next_state     = SPU_READY;
                        end
                        default: begin
                            next_data_ready = 1'b1;
                            next_state      = SPU_DATA;
                        end
                    endcase
                end
            end
            SPU_READY: begin
                next_cmd_ready = 1'b1;
                if (cmd_valid && cmd_ready) begin
                    next_cmd_ready = 1'b0;
                    // Unknown codes are refused here rather than left to time out
                    if (cmd_known(cmd_code)) begin
                        next_sent     = cmd_code;
                        next_phase    = SPU_PH_CMD;
                        next_tx_valid = 1'b1;
                        next_state    = SPU_SEND;
                    end else begin
                        next_cmd_reject = 1'b1;
                    end
                end
            end
            SPU_DATA: begin
                // Reply latency depends on the command; the user paces it
                if (link.rx_valid) begin
                    next_resp_valid = 1'b1;
                    next_resp_byte  = link.rx_data;
                end
                if (tx_valid && link.tx_ready) begin
                    next_data_ready = 1'b1;
                end
                if (cmd_done) begin
                    next_data_ready = 1'b0;
                    next_cnt        = NEXT_WAIT;
                    next_state      = SPU_NEXT;
                end else if (data_valid && data_ready) begin
                    next_sent       = data_byte;
                    next_tx_valid   = 1'b1;
                    next_data_ready = 1'b0;
                end
            end
            SPU_NEXT: begin
                if (cnt == 32'h0000_0000 && !tx_valid) begin
                    next_cmd_ready = 1'b1;
                    next_state     = SPU_READY;
                end
            end
            SPU_ERR: begin
            end
            default: begin
                next_state = SPU_IDLE;
            end
        endcase
        // A new session restarts from any state
        if (session_start) begin
            next_state      = SPU_HOLD;
            next_cnt        = RESET_HOLD;
            next_mode       = 1'b0;
            next_reset_n    = 1'b0;
            next_link_error = 1'b0;
            next_tx_valid   = 1'b0;
            next_data_ready = 1'b0;
            next_cmd_ready  = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state       <= SPU_IDLE;
            phase       <= SPU_PH_SYNC1;
            cnt         <= 32'h0000_0000;
            sent        <= 8'h00;
            tx_valid    <= 1'b0;
            data_ready  <= 1'b0;
            resp_valid  <= 1'b0;
            resp_byte   <= 8'h00;
            cmd_ready   <= 1'b0;
            cmd_reject  <= 1'b0;
            link_error  <= 1'b0;
            dev_mode    <= 1'b0;
            dev_reset_n <= 1'b0;
        end else begin
            state       <= next_state;
            phase       <= next_phase;
            cnt         <= next_cnt;
            sent        <= next_sent;
            tx_valid    <= next_tx_valid;
            data_ready  <= next_data_ready;
            resp_valid  <= next_resp_valid;
            resp_byte   <= next_resp_byte;
            cmd_ready   <= next_cmd_ready;
            cmd_reject  <= next_cmd_reject;
            link_error  <= next_link_error;
            dev_mode    <= next_mode;
            dev_reset_n <= next_reset_n;
        end
    end
endmodule : spu_host
`default_nettype wire

// ===== spu_host_checker.sv
`timescale 1ns/100ps
`default_nettype none
module spu_host_checker
    import spu_pkg::*;
#(
    parameter logic [31:0] RESET_HOLD = RESET_HOLD_CYC,
    parameter logic [31:0] START_WAIT = START_WAIT_CYC,
    parameter logic [31:0] NEXT_WAIT  = NEXT_CMD_CYC,
    parameter int          BAUD_DIV   = int'(UART_DIV)
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       srst,
    // User side
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic       cmd_done,
    input wire logic       data_ready,
    input wire logic       cmd_ready,
    input wire logic       cmd_reject,
    // Device pins
    input wire logic       dev_reset_n,
    input wire logic       dev_rxd,
    input wire logic       dev_txd
);
    logic [31:0] low_cnt, high_cnt, quiet_cnt, done_cnt, busy;
    logic [1:0]  nfr;
    logic        pend, rx_prev, start_rx, known;

    // Zero data bits inside a frame must not count as frame starts
    assign start_rx = rx_prev && !dev_rxd && busy == 32'h0;
    assign known = cmd_code inside {CMD_ERASE, CMD_WRITE, CMD_READ, CMD_SUM,
                                    CMD_PROD_ID, CMD_STATUS, CMD_EMULATION};

    always_ff @(posedge core_clk) begin
        rx_prev   <= srst || dev_rxd;
        // Frame window must start cleared, or every later start test is unknown
        if (srst)
            busy <= 32'h0;
        else if (start_rx)
            busy <= 32'(9 * BAUD_DIV);
        else if (busy != 32'h0)
            busy <= busy - 32'h1;
        low_cnt   <= (srst || dev_reset_n) ? 32'h0 : low_cnt + 32'h1;
        high_cnt  <= (srst || !dev_reset_n) ? 32'h0 : high_cnt + 32'h1;
        quiet_cnt <= (srst || !dev_txd) ? 32'h0 : quiet_cnt + 32'h1;
        done_cnt  <= (srst || cmd_done) ? 32'h1 : done_cnt + 32'h1;
        pend      <= !srst && (cmd_done || (pend && !cmd_ready));
        if (srst || !dev_reset_n)
            nfr <= 2'h0;
        else if (start_rx && nfr != 2'h3)
            nfr <= nfr + 2'h1;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_refused;
        cmd_reject && !cmd_ready ##1 !cmd_reject && cmd_ready;
    endsequence
    sequence s_taken;
        !cmd_ready && !cmd_reject;
    endsequence

    hold_low_a: assert property (
        $rose(dev_reset_n) |-> low_cnt >= RESET_HOLD) else $error("pins released early");
    start_wait_a: assert property (
        !(dev_reset_n && high_cnt >= START_WAIT) |-> dev_rxd) else $error("byte sent early");
    sync_gap_a: assert property (
        start_rx && nfr == 2'h1 |-> quiet_cnt >= GAP_SYNC1_CYC) else $error("gap after 86 short");
    cmd_gap_a: assert property (
        start_rx && nfr == 2'h2 |-> quiet_cnt >= GAP_SYNC2_CYC) else $error("gap after 79 short");
    data_gap_a: assert property (
        $rose(data_ready) |-> quiet_cnt >= GAP_CMD_CYC) else $error("data phase opened early");
    next_cmd_a: assert property (
        $rose(cmd_ready) && pend |-> done_cnt >= NEXT_WAIT) else $error("next command early");
    refuse_code_a: assert property (
        cmd_valid && cmd_ready && !known |=> s_refused) else $error("unknown code taken");
    take_code_a: assert property (
        cmd_valid && cmd_ready && known |=> s_taken) else $error("known code refused");
endmodule : spu_host_checker

bind spu_host spu_host_checker #(
    .RESET_HOLD (RESET_HOLD),
    .START_WAIT (START_WAIT),
    .NEXT_WAIT  (NEXT_WAIT),
    .BAUD_DIV   (BAUD_DIV)
) u_spu_host_checker (
    .core_clk (core_clk), .srst (srst), .cmd_valid (cmd_valid), .cmd_code (cmd_code),
    .cmd_done (cmd_done), .data_ready (data_ready), .cmd_ready (cmd_ready),
    .cmd_reject (cmd_reject), .dev_reset_n (dev_reset_n), .dev_rxd (dev_rxd),
    .dev_txd (dev_txd)
);
`default_nettype wire

// ===== spu_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module spu_dev_model
    import spu_pkg::*;
#(
    parameter int BIT  = 8,
    // Core cycles per gear cycle; a fast target keeps the run short
    parameter int GEAR = 4
) (
    // Clock
    input  wire logic core_clk,
    // Device pins
    input  wire logic mode,
    input  wire logic reset_n,
    input  wire logic rxd,
    output var  logic txd,
    // Test controls
    input  wire logic cmd_end,
    input  wire logic bad_echo
);
    int         nrx    = 0;
    logic       in_cmd = 1'b0;
    logic [7:0] cmd;
    logic [7:0] b;

    // Released line rests high through its pull-up
    initial txd = 1'b1;

    always @(negedge reset_n) begin
        nrx    = 0;
        in_cmd = 1'b0;
    end
    always @(posedge core_clk) begin
        if (cmd_end)
            in_cmd = 1'b0;
    end

    task automatic put(input logic [7:0] v, input int gear);
        repeat (gear * GEAR) @(posedge core_clk);
        for (int i = 0; i < 10; i++) begin
            txd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i - 1];
            repeat (BIT) @(posedge core_clk);
        end
    endtask : put

    // One byte at a time: a new frame is not heard while a reply is pending
    initial begin
        forever begin
            @(negedge rxd);
            if (!(reset_n && mode))
                continue;
            repeat (BIT / 2) @(posedge core_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge core_clk);
                b[i] = rxd;
            end
            repeat (BIT) @(posedge core_clk);
            if (nrx == 0)
                put(b, 660);
            else if (nrx == 1)
                put(b, 540);
            else if (!in_cmd) begin
                cmd    = b;
                in_cmd = 1'b1;
                put(bad_echo ? ~b : b, 300);
            end else begin
                case (cmd)
                    CMD_WRITE:     put(~b, 200);
                    CMD_READ:      put(~b, 430);
                    CMD_EMULATION: put(b, 420);
                    // Long checksum and protection work is cut to the short figure
                    default:       put(~b, 160);
                endcase
            end
            nrx++;
        end
    end
endmodule : spu_dev_model
`default_nettype wire

// ===== spu_host_tb.sv
`timescale 1ns/100ps
`default_nettype none
module spu_host_tb
    import spu_pkg::*;
;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
        logic [7:0] resp;
        logic       known;
    } spu_row_t;

    // Reply is the inverted byte, except emulation data which comes back as sent
    localparam spu_row_t ROWS [8] = '{
        '{CMD_ERASE, 8'hA5, 8'h5A, 1'b1}, '{CMD_WRITE, 8'h01, 8'hFE, 1'b1},
        '{CMD_READ, 8'h80, 8'h7F, 1'b1}, '{CMD_SUM, 8'h00, 8'hFF, 1'b1},
        '{CMD_PROD_ID, 8'hFF, 8'h00, 1'b1}, '{CMD_STATUS, 8'h3C, 8'hC3, 1'b1},
        '{CMD_EMULATION, 8'h96, 8'h96, 1'b1}, '{8'h31, 8'h00, 8'h00, 1'b0}
    };

    logic       core_clk, srst, session_start, cmd_valid, cmd_done, data_valid, bad_echo;
    logic       data_ready, resp_valid, cmd_ready, cmd_reject, link_error, rej;
    logic       dev_mode, dev_reset_n, dev_rxd, dev_txd;
    logic [7:0] cmd_code, data_byte, resp_byte;
    int         fails  = 0;
    int         checks = 0;

    // Short counts keep the run brief
    spu_host #(
        .RESET_HOLD (32'h14), .START_WAIT (32'h28), .NEXT_WAIT (32'h1E),
        .ECHO_TMO (32'h4E20), .BAUD_DIV (32'h8)
    ) u_spu_host (
        .core_clk (core_clk), .srst (srst), .session_start (session_start),
        .cmd_valid (cmd_valid), .cmd_code (cmd_code), .cmd_done (cmd_done),
        .data_valid (data_valid), .data_byte (data_byte), .data_ready (data_ready),
        .resp_valid (resp_valid), .resp_byte (resp_byte), .cmd_ready (cmd_ready),
        .cmd_reject (cmd_reject), .link_error (link_error), .dev_mode (dev_mode),
        .dev_reset_n (dev_reset_n), .dev_rxd (dev_rxd), .dev_txd (dev_txd)
    );

    spu_dev_model u_spu_dev_model (
        .core_clk (core_clk), .mode (dev_mode), .reset_n (dev_reset_n), .rxd (dev_rxd),
        .txd (dev_txd), .cmd_end (cmd_done), .bad_echo (bad_echo)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (s !== 1'b1 && n < 15000);
        check(8'(s), 8'h01);
    endtask : wait_hi

    task automatic issue(input logic [7:0] code);
        wait_hi(cmd_ready);
        cmd_code  <= code;
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
    endtask : issue

    task automatic results();
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial begin
        // Tests take about 66500 cycles; the margin still keeps the run bounded
        repeat (90000) @(posedge core_clk);
        fails++;
        results();
    end

    initial begin
        {srst, session_start, cmd_valid, cmd_done, data_valid, bad_echo} = 6'h20;
        cmd_code  = 8'h00;
        data_byte = 8'h00;
        repeat (4) @(posedge core_clk);
        check(8'({dev_mode, dev_reset_n, dev_rxd, cmd_ready}), 8'h02);
        srst          <= 1'b0;
        session_start <= 1'b1;
        @(posedge core_clk);
        session_start <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(8'({dev_mode, dev_reset_n, dev_rxd}), 8'h01);
        wait_hi(cmd_ready);
        foreach (ROWS[i]) begin
            issue(ROWS[i].code);
            rej = 1'b0;
            repeat (3) begin
                @(posedge core_clk);
                rej = rej | cmd_reject;
            end
            check(8'(rej), 8'(!ROWS[i].known));
            if (ROWS[i].known) begin
                wait_hi(data_ready);
                data_byte  <= ROWS[i].data;
                data_valid <= 1'b1;
                @(posedge core_clk);
                data_valid <= 1'b0;
                wait_hi(resp_valid);
                check(resp_byte, ROWS[i].resp);
                cmd_done <= 1'b1;
                @(posedge core_clk);
                cmd_done <= 1'b0;
            end
        end
        // A corrupted echo leaves the link dead, deaf to any further command
        bad_echo <= 1'b1;
        issue(CMD_STATUS);
        wait_hi(link_error);
        cmd_code  <= 8'h31;
        cmd_valid <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(8'({cmd_ready, cmd_reject, data_ready, link_error}), 8'h01);
        cmd_valid <= 1'b0;
        results();
    end
endmodule : spu_host_tb
`default_nettype wire
